// ==== core/tx_coding_consts.vh ====
// Register map, field positions, reset values and coding constants
`ifndef TX_CODING_CONSTS_VH
`define TX_CODING_CONSTS_VH

// Register addresses
`define ADDR_MOD_FIRST      5'h00
`define ADDR_MOD_SECOND     5'h01
`define ADDR_DEVIATION      5'h02
`define ADDR_PACKET_CTRL    5'h03
`define ADDR_PA_CTRL        5'h04
`define ADDR_STATUS         5'h05
`define ADDR_POWER_HI       2'h1

// Field positions
`define MF_MOD_LO           0
`define MF_MOD_HI           1
`define MF_BT               2
`define MF_CW               3
`define MF_REXP_LO          4
`define MF_REXP_HI          7
`define DV_MANT_LO          0
`define DV_MANT_HI          2
`define DV_EXP_LO           3
`define DV_EXP_HI           6
`define PC_CRC_LO           0
`define PC_CRC_HI           2
`define PC_WHIT             3
`define PC_FEC              4
`define PA_TOP_LO           0
`define PA_TOP_HI           2
`define PA_RAMP             3

// Reset values
`define RST_MOD_FIRST       8'h00
`define RST_MOD_SECOND      8'h00
`define RST_DEVIATION       8'h00
`define RST_PACKET_CTRL     8'h00
`define RST_PA_CTRL         8'h07
`define RST_POWER           7'h00

// Modulation select codes
`define MOD_FSK             2'h0
`define MOD_GFSK            2'h1
`define MOD_AMPL            2'h2
`define MOD_MSK             2'h3

// CRC polynomials, left aligned
`define CRC_POLY_8          24'h07_0000
`define CRC_POLY_16A        24'h80_0500
`define CRC_POLY_16B        24'h10_2100
`define CRC_POLY_24         24'h86_4cfb
`define CRC_INIT            24'h00_0000

`define WHIT_INIT           9'h1ff
`define RATE_BASE           9'h100
`define SUB_LAST            3'h7

`endif

// ==== core/tx_coding_chain.v ====
// Transmit modulation control and packet coding chain
`timescale 1ns/1ps
`default_nettype none
`include "tx_coding_consts.vh"

// Summary of operation
// RL1 - Modulation select 0 gives 2-FSK, 1 gives GFSK.
// RL2 - Select 2 gives ASK with power ramping on, OOK with it off.
// RL3 - FSK deviation word floor((8+mantissa)*2^(exponent-1)) over 2^18.
// RL4 - Host keeps deviation mantissa 3 bits and exponent within 0 to 9.
// RL5 - GFSK shaping BT selects 1 or 0.5 from one field.
// RL6 - MSK forces deviation to a quarter of the data rate.
// RL7 - OOK sends one at the top table entry, zero at entry 0.
// RL8 - ASK ramps power up for one, down for zero, eighth-symbol steps.
// RL9 - ASK holds top entry on repeated ones, entry 0 on repeated zeros.
// RL10 - Carrier-only sends a plain carrier; host keeps a test source on.
// RL11 - Symbol rate is clock*(256+mantissa)*2^exponent/2^28.
// RL12 - FEC codes payload and CRC at rate 1/2, k=4, polys 13 and 17.
// RL13 - Coded bits go through a 4x4 interleaver, rows in, columns out.
// RL14 - The FEC enable switches coding and interleaving together.
// RL15 - With FEC a termination byte returns the encoder to zero state.
// RL16 - With FEC an odd payload plus CRC count gets one filler byte.
// RL17 - Rate setting is the on-air symbol rate, so FEC doubles duration.
// RL18 - Checksum select 1 is CRC-8 0x07, 2 is CRC-16 0x8005.
// RL19 - Checksum select 3 is CRC-16 0x1021, 4 is CRC-24 0x864CFB.
// RL20 - CRC covers all fields but preamble and sync, appended at end.
// RL21 - Whitening XORs data with 9-bit all-ones seeded LFSR sequence.
// RL22 - Whitening covers all fields but preamble and sync.
// RL23 - Host should always enable whitening.
// RL24 - Top level index is a 3-bit pointer into eight power entries.
// RL25 - Whitening LFSR uses x^9+x^5+1, one step per whitened bit.
// RL26 - Order is CRC, then whitening, then FEC with interleaving.
module tx_coding_chain (
    input  wire        core_clk,
    input  wire        rst,
    input  wire [4:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata_q,
    input  wire        in_valid,
    input  wire [7:0]  in_data,
    input  wire        in_raw,
    input  wire        in_last,
    output reg         in_ready_q,
    output reg         tx_bit_q,
    output reg         symbol_tick_q,
    output reg  [6:0]  pa_level_q,
    output reg  [17:0] deviation_q,
    output reg  [1:0]  modulation_q,
    output reg         gaussian_q,
    output reg         gaussian_bt_q,
    output reg         carrier_only_q,
    output reg         tx_active_q
);

    localparam [3:0] S_DATA = 4'h1;
    localparam [3:0] S_CRC  = 4'h2;
    localparam [3:0] S_PAD  = 4'h4;
    localparam [3:0] S_TERM = 4'h8;

    // One CRC step per bit, MSB first, register left aligned
    function [23:0] crc_byte;
        input [23:0] c;
        input [7:0]  b;
        input [23:0] p;
        integer      i;
        reg   [23:0] r;
        begin
            r = c;
            for (i = 7; i >= 0; i = i - 1) begin
                if (b[i] ^ r[23])
                    r = {r[22:0], 1'b0} ^ p;
                else
                    r = {r[22:0], 1'b0};
            end
            crc_byte = r;
        end
    endfunction

    // Returns {next lfsr, mask byte MSB first}
    function [16:0] whit_byte;
        input [8:0] l;
        integer     i;
        reg   [8:0] r;
        reg   [7:0] m;
        begin
            r = l;
            m = 8'h00;
            for (i = 7; i >= 0; i = i - 1) begin
                m[i] = r[0];
                r = {r[4] ^ r[0], r[8:1]};
            end
            whit_byte = {r, m};
        end
    endfunction

    // Returns {next state, 16 coded bits, first in time at bit 15}
    function [18:0] conv_byte;
        input [2:0] s;
        input [7:0] b;
        integer     i;
        reg   [2:0] r;
        reg   [15:0] o;
        begin
            r = s;
            o = 16'h0000;
            for (i = 7; i >= 0; i = i - 1) begin
                o[2*i+1] = b[i] ^ r[1] ^ r[0];
                o[2*i]   = b[i] ^ r[2] ^ r[1] ^ r[0];
                r = {b[i], r[2:1]};
            end
            conv_byte = {r, o};
        end
    endfunction

    // Write rows, read columns
    function [15:0] interleave;
        input [15:0] t;
        integer      k;
        reg   [15:0] o;
        begin
            o = 16'h0000;
            for (k = 0; k < 16; k = k + 1)
                o[15-k] = t[15 - ((k % 4) * 4 + (k / 4))];
            interleave = o;
        end
    endfunction

    reg  [7:0]  mod_first_q;
    reg  [7:0]  mod_second_q;
    reg  [7:0]  dev_cfg_q;
    reg  [7:0]  pkt_ctrl_q;
    reg  [7:0]  pa_ctrl_q;
    reg  [6:0]  pwr_q [0:7];

    wire [1:0]  modulation_select  = mod_first_q[`MF_MOD_HI:`MF_MOD_LO];
    wire        gaussian_bt_select = mod_first_q[`MF_BT];
    wire        carrier_only       = mod_first_q[`MF_CW];
    wire [3:0]  rate_exponent      = mod_first_q[`MF_REXP_HI:`MF_REXP_LO];
    wire [7:0]  rate_mantissa      = mod_second_q;
    wire [2:0]  deviation_mantissa = dev_cfg_q[`DV_MANT_HI:`DV_MANT_LO];
    wire [3:0]  deviation_exponent = dev_cfg_q[`DV_EXP_HI:`DV_EXP_LO];
    wire [2:0]  crc_select         = pkt_ctrl_q[`PC_CRC_HI:`PC_CRC_LO];
    wire        whitening_enable   = pkt_ctrl_q[`PC_WHIT];
    wire        fec_enable         = pkt_ctrl_q[`PC_FEC];
    wire [2:0]  top_level_index    = pa_ctrl_q[`PA_TOP_HI:`PA_TOP_LO];
    wire        ramp_enable        = pa_ctrl_q[`PA_RAMP];

    always @(posedge core_clk) begin
        if (rst) begin
            mod_first_q  <= `RST_MOD_FIRST;
            mod_second_q <= `RST_MOD_SECOND;
            dev_cfg_q    <= `RST_DEVIATION;
            pkt_ctrl_q   <= `RST_PACKET_CTRL;
            pa_ctrl_q    <= `RST_PA_CTRL;
        end else if (reg_wr) begin
            case (reg_addr)
                `ADDR_MOD_FIRST:   mod_first_q  <= reg_wdata;
                `ADDR_MOD_SECOND:  mod_second_q <= reg_wdata;
                `ADDR_DEVIATION:   dev_cfg_q    <= reg_wdata;
                `ADDR_PACKET_CTRL: pkt_ctrl_q   <= reg_wdata;
                `ADDR_PA_CTRL:     pa_ctrl_q    <= reg_wdata;
                default: ;
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : pwr_entry
            always @(posedge core_clk) begin
                if (rst)
                    pwr_q[g] <= `RST_POWER;
                else if (reg_wr && reg_addr[4:3] == `ADDR_POWER_HI &&
                         reg_addr[2:0] == g)
                    pwr_q[g] <= reg_wdata[6:0];
            end
        end
    endgenerate

    // Accumulator carries at eight times the symbol rate
    wire [23:0] rate_inc = {15'h0000, `RATE_BASE | {1'b0, rate_mantissa}}
                           << rate_exponent;                      // [RL11]
    reg  [24:0] acc_q;
    reg  [2:0]  sub_q;
    wire [25:0] acc_sum = {1'b0, acc_q} + {2'b00, rate_inc};
    wire        eighth  = acc_sum[25];
    wire        sym     = eighth && (sub_q == `SUB_LAST);        // [RL17]

    always @(posedge core_clk) begin
        if (rst) begin
            acc_q <= 25'h000_0000;
            sub_q <= 3'h0;
        end else begin
            acc_q <= acc_sum[24:0];
            if (eighth)
                sub_q <= sub_q + 3'h1;
        end
    end

    reg  [3:0]  st_q, st_d;
    reg  [1:0]  left_q, left_d;
    reg  [23:0] crc_q, crc_d;
    reg  [8:0]  lfsr_q, lfsr_d;
    reg  [2:0]  conv_q, conv_d;
    reg         par_q, par_d;
    reg  [15:0] sh_q, sh_d;
    reg  [4:0]  cnt_q, cnt_d;

    wire        take = in_valid && in_ready_q;

    reg  [23:0] crc_poly;
    reg  [1:0]  crc_len;
    always @* begin
        crc_poly = `CRC_POLY_8;
        crc_len  = 2'd0;
        case (crc_select)
            3'h1: begin crc_poly = `CRC_POLY_8;   crc_len = 2'd1; end // [RL18]
            3'h2: begin crc_poly = `CRC_POLY_16A; crc_len = 2'd2; end // [RL18]
            3'h3: begin crc_poly = `CRC_POLY_16B; crc_len = 2'd2; end // [RL19]
            3'h4: begin crc_poly = `CRC_POLY_24;  crc_len = 2'd3; end // [RL19]
            default: ;
        endcase
    end

    reg         ld, ld_crc, ld_whit, ld_code, par_flip, crc_shift, finish;
    reg  [7:0]  ld_byte, wbyte;
    reg  [16:0] wb;
    reg  [18:0] cb;

    always @* begin
        ld        = 1'b0;
        ld_byte   = 8'h00;
        ld_crc    = 1'b0;
        ld_whit   = 1'b0;
        ld_code   = 1'b0;
        par_flip  = 1'b0;
        crc_shift = 1'b0;
        st_d      = st_q;
        left_d    = left_q;
        case (st_q)
            S_DATA: begin
                if (take) begin
                    ld       = 1'b1;
                    ld_byte  = in_data;
                    ld_crc   = !in_raw;                          // [RL20]
                    ld_whit  = !in_raw && whitening_enable;      // [RL22]
                    ld_code  = !in_raw && fec_enable;            // [RL12]
                    par_flip = !in_raw;
                    if (in_last) begin
                        if (crc_len != 2'd0) begin
                            st_d   = S_CRC;                      // [RL20]
                            left_d = crc_len;
                        end else if (fec_enable)
                            st_d = (par_q ^ par_flip) ? S_PAD : S_TERM;
                    end
                end
            end
            S_CRC: begin
                if (cnt_q == 5'd0) begin
                    ld        = 1'b1;
                    ld_byte   = crc_q[23:16];
                    ld_whit   = whitening_enable;                // [RL22]
                    ld_code   = fec_enable;                      // [RL12]
                    par_flip  = 1'b1;
                    crc_shift = 1'b1;
                    left_d    = left_q - 2'd1;
                    if (left_q == 2'd1) begin
                        if (fec_enable)
                            st_d = par_q ? S_TERM : S_PAD;       // [RL16]
                        else
                            st_d = S_DATA;
                    end
                end
            end
            S_PAD: begin
                if (cnt_q == 5'd0) begin
                    ld      = 1'b1;
                    ld_whit = whitening_enable;
                    ld_code = 1'b1;                              // [RL16]
                    st_d    = S_TERM;
                end
            end
            S_TERM: begin
                if (cnt_q == 5'd0) begin
                    ld      = 1'b1;
                    ld_code = 1'b1;                              // [RL15]
                    st_d    = S_DATA;
                end
            end
            default: st_d = S_DATA;
        endcase
        finish = ld && (st_d == S_DATA) && ((st_q != S_DATA) || in_last);
    end

    // Byte through CRC, whitening, encoder and interleaver
    always @* begin
        crc_d  = crc_q;
        lfsr_d = lfsr_q;
        conv_d = conv_q;
        par_d  = par_q;
        sh_d   = sh_q;
        cnt_d  = cnt_q;
        wb     = whit_byte(lfsr_q);
        wbyte  = ld_whit ? (ld_byte ^ wb[7:0]) : ld_byte;        // [RL21]
        cb     = conv_byte(conv_q, wbyte);
        if (sym && cnt_q != 5'd0) begin
            sh_d  = {sh_q[14:0], 1'b0};
            cnt_d = cnt_q - 5'd1;
        end
        if (ld) begin
            par_d = par_q ^ par_flip;
            if (ld_crc)
                crc_d = crc_byte(crc_q, ld_byte, crc_poly);      // [RL26]
            else if (crc_shift)
                crc_d = {crc_q[15:0], 8'h00};
            if (ld_whit)
                lfsr_d = wb[16:8];                               // [RL25]
            if (ld_code) begin
                conv_d = cb[18:16];
                sh_d   = interleave(cb[15:0]);                   // [RL13]
                cnt_d  = 5'd16;                                  // [RL14]
            end else begin
                sh_d  = {wbyte, 8'h00};
                cnt_d = 5'd8;
            end
        end
        if (finish) begin
            crc_d  = `CRC_INIT;
            lfsr_d = `WHIT_INIT;                                 // [RL21]
            conv_d = 3'h0;
            par_d  = 1'b0;
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            st_q       <= S_DATA;
            left_q     <= 2'd0;
            crc_q      <= `CRC_INIT;
            lfsr_q     <= `WHIT_INIT;
            conv_q     <= 3'h0;
            par_q      <= 1'b0;
            sh_q       <= 16'h0000;
            cnt_q      <= 5'd0;
            in_ready_q <= 1'b0;
            tx_active_q <= 1'b0;
        end else begin
            st_q       <= st_d;
            left_q     <= left_d;
            crc_q      <= crc_d;
            lfsr_q     <= lfsr_d;
            conv_q     <= conv_d;
            par_q      <= par_d;
            sh_q       <= sh_d;
            cnt_q      <= cnt_d;
            in_ready_q <= (st_d == S_DATA) && (cnt_d == 5'd0);
            // Stays up through the last symbol so its power level holds
            tx_active_q <= (st_d != S_DATA) || (cnt_d != 5'd0) ||
                           (tx_active_q && !(sym && cnt_q == 5'd0));
        end
    end

    // Bit to the modulator, one per symbol
    always @(posedge core_clk) begin
        if (rst) begin
            tx_bit_q      <= 1'b0;
            symbol_tick_q <= 1'b0;
        end else begin
            symbol_tick_q <= sym && (cnt_q != 5'd0);
            if (sym && cnt_q != 5'd0)
                tx_bit_q <= sh_q[15];
        end
    end

    // Amplitude keying ramp, one step per eighth symbol
    wire        ampl_mode = (modulation_select == `MOD_AMPL);
    wire        ask_mode  = ampl_mode && ramp_enable;            // [RL2]
    wire        ook_mode  = ampl_mode && !ramp_enable;           // [RL2]
    reg  [2:0]  ramp_q, pa_idx;

    always @(posedge core_clk) begin
        if (rst)
            ramp_q <= 3'h0;
        else if (!ask_mode || !tx_active_q)
            ramp_q <= 3'h0;
        else if (ramp_q > top_level_index)
            ramp_q <= top_level_index;
        else if (eighth) begin
            if (tx_bit_q && ramp_q != top_level_index)
                ramp_q <= ramp_q + 3'h1;                         // [RL8]
            else if (!tx_bit_q && ramp_q != 3'h0)
                ramp_q <= ramp_q - 3'h1;                         // [RL9]
        end
    end

    always @* begin
        if (!tx_active_q)
            pa_idx = 3'h0;
        else if (carrier_only)
            pa_idx = top_level_index;                            // [RL10]
        else if (ask_mode)
            pa_idx = ramp_q;                                     // [RL8]
        else if (ook_mode)
            pa_idx = tx_bit_q ? top_level_index : 3'h0;          // [RL7]
        else
            pa_idx = top_level_index;
    end

    wire [3:0]  dev_base = {1'b1, deviation_mantissa};
    wire [3:0]  dev_sh   = deviation_exponent - 4'h1;
    wire [17:0] dev_fsk  = (deviation_exponent == 4'h0) ?
                           {15'h0000, dev_base[3:1]} :
                           ({14'h0000, dev_base} << dev_sh);     // [RL3]
    wire [17:0] dev_msk  = {6'h00, rate_inc[23:12]};             // [RL6]

    always @(posedge core_clk) begin
        if (rst) begin
            pa_level_q     <= `RST_POWER;
            deviation_q    <= 18'h0_0000;
            modulation_q   <= `MOD_FSK;
            gaussian_q     <= 1'b0;
            gaussian_bt_q  <= 1'b0;
            carrier_only_q <= 1'b0;
        end else begin
            pa_level_q     <= pwr_q[pa_idx];
            modulation_q   <= modulation_select;                 // [RL1]
            gaussian_q     <= (modulation_select == `MOD_GFSK);  // [RL1]
            gaussian_bt_q  <= gaussian_bt_select;                // [RL5]
            carrier_only_q <= carrier_only;                      // [RL10]
            if (carrier_only || ampl_mode)
                deviation_q <= 18'h0_0000;
            else if (modulation_select == `MOD_MSK)
                deviation_q <= dev_msk;                          // [RL6]
            else
                deviation_q <= dev_fsk;                          // [RL3]
        end
    end

    // Register reads, data in the cycle after the strobe
    always @(posedge core_clk) begin
        if (rst || !reg_rd)
            reg_rdata_q <= 8'h00;
        else if (reg_addr[4:3] == `ADDR_POWER_HI)
            reg_rdata_q <= {1'b0, pwr_q[reg_addr[2:0]]};
        else begin
            case (reg_addr)
                `ADDR_MOD_FIRST:   reg_rdata_q <= mod_first_q;
                `ADDR_MOD_SECOND:  reg_rdata_q <= mod_second_q;
                `ADDR_DEVIATION:   reg_rdata_q <= dev_cfg_q;
                `ADDR_PACKET_CTRL: reg_rdata_q <= pkt_ctrl_q;
                `ADDR_PA_CTRL:     reg_rdata_q <= pa_ctrl_q;
                `ADDR_STATUS:
                    reg_rdata_q <= {tx_active_q, in_ready_q, par_q,
                                    1'b0, st_q};
                default:           reg_rdata_q <= 8'h00;
            endcase
        end
    end

endmodule
`default_nettype wire

// ==== verification/tx_chain_chk.sv ====
// Port checker for the transmit coding chain
`timescale 1ns/1ps
`default_nettype none
module tx_chain_chk (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic [4:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        in_valid,
    input wire logic        in_ready_q,
    input wire logic        tx_bit_q,
    input wire logic        symbol_tick_q,
    input wire logic [17:0] deviation_q,
    input wire logic [1:0]  modulation_q,
    input wire logic        gaussian_q,
    input wire logic        gaussian_bt_q,
    input wire logic        carrier_only_q,
    input wire logic        tx_active_q
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    logic [7:0] mod_wr_q;
    always @(posedge core_clk)
        if (reg_wr && reg_addr == 5'h00) mod_wr_q <= reg_wdata;
    gauss_follow_a: assert property (
        $stable(modulation_q) |-> gaussian_q == (modulation_q == 2'h1))
        else $error("gaussian flag wrong");
    ampl_nodev_a: assert property (
        modulation_q == 2'h2 [*2] |-> deviation_q == 18'h0)
        else $error("ampl deviation set");
    mod_copy_a: assert property (
        reg_wr && reg_addr == 5'h00 ##1 !reg_wr [*2] |->
        modulation_q == mod_wr_q[1:0] && gaussian_bt_q == mod_wr_q[2])
        else $error("mod outputs stale");
    cw_nodev_a: assert property (
        carrier_only_q [*2] |-> deviation_q == 18'h0)
        else $error("carrier deviation set");
    tick_spacing_a: assert property (
        symbol_tick_q |=> !symbol_tick_q [*7])
        else $error("ticks too close");
    bit_on_tick_a: assert property (
        $changed(tx_bit_q) |-> symbol_tick_q)
        else $error("bit moved off tick");
    ready_hold_a: assert property (
        in_valid && in_ready_q |=> !in_ready_q [*8])
        else $error("ready too early");
    take_active_a: assert property (
        in_valid && in_ready_q |=> tx_active_q)
        else $error("not active");
    cover property (in_valid && in_ready_q);
    cover property (symbol_tick_q && tx_bit_q);
    cover property (modulation_q == 2'h3);
endmodule
bind tx_coding_chain tx_chain_chk chk_u (.core_clk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .in_valid, .in_ready_q, .tx_bit_q, .symbol_tick_q,
    .deviation_q, .modulation_q, .gaussian_q, .gaussian_bt_q,
    .carrier_only_q, .tx_active_q);
`default_nettype wire

// ==== verification/rf_output_model.sv ====
// Modulator and power stage model that records what it is sent
`timescale 1ns/1ps
`default_nettype none
module rf_output_model (
    input wire logic       core_clk,
    input wire logic       tx_bit_q,
    input wire logic       symbol_tick_q,
    input wire logic [6:0] pa_level_q
);
    logic       bits[$];
    logic [6:0] levels[$];
    logic [1:0] tick_d = 2'b00;
    // Power lags the bit by one register, so read it two cycles in
    always @(posedge core_clk) begin
        tick_d <= {tick_d[0], symbol_tick_q};
        if (symbol_tick_q) bits.push_back(tx_bit_q);
        if (tick_d[1]) levels.push_back(pa_level_q);
    end
endmodule
`default_nettype wire

// ==== verification/tx_modulation_coding_chain_tb.sv ====
// Self-checking bench for the transmit coding chain
`timescale 1ns/1ps
`default_nettype none
module tx_modulation_coding_chain_tb;
    logic        core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        in_valid = 1'b0, in_raw = 1'b0, in_last = 1'b0;
    logic [4:0]  reg_addr = 5'h00;
    logic [7:0]  reg_wdata = 8'h00, in_data = 8'h00;
    wire  [7:0]  reg_rdata_q;
    wire         in_ready_q, tx_bit_q, symbol_tick_q, gaussian_q;
    wire         gaussian_bt_q, carrier_only_q, tx_active_q;
    wire  [6:0]  pa_level_q;
    wire  [17:0] deviation_q;
    wire  [1:0]  modulation_q;
    int          failures = 0, samples_checked = 0, cycles = 0;
    logic        exp_q[$];
    logic [8:0]  lfsr;
    logic [2:0]  cst;
    localparam logic [23:0] crc_poly [5] = '{24'h0, 24'h07_0000,
        24'h80_0500, 24'h10_2100, 24'h86_4cfb};
    localparam int crc_bytes [5] = '{0, 1, 2, 2, 3};
    localparam logic [7:0] pkt_cfg [9] = '{8'h00, 8'h09, 8'h02, 8'h0b,
        8'h04, 8'h19, 8'h1b, 8'h00, 8'h00};
    localparam logic [7:0] pkt [3] = '{8'hd3, 8'h5a, 8'h0f};

    always #5 core_clk = ~core_clk;

    tx_coding_chain dut_u (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata_q, .in_valid, .in_data, .in_raw, .in_last,
        .in_ready_q, .tx_bit_q, .symbol_tick_q, .pa_level_q, .deviation_q,
        .modulation_q, .gaussian_q, .gaussian_bt_q, .carrier_only_q,
        .tx_active_q);
    rf_output_model model_u (.core_clk, .tx_bit_q, .symbol_tick_q,
        .pa_level_q);

    task automatic check(input string what, input logic [23:0] seen,
                         input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rdc(input string what, input logic [4:0] a,
                       input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 check(what, reg_rdata_q, e);
        @(posedge core_clk);
    endtask

    task automatic put(input logic [7:0] b, input logic raw, input logic last);
        in_data <= b;
        in_raw <= raw;
        in_last <= last;
        in_valid <= 1'b1;
        do @(posedge core_clk); while (in_ready_q !== 1'b1);
        if (last) in_valid <= 1'b0;
    endtask

    // Reference coding of one byte, MSB first
    task automatic emit(input logic [7:0] b, input logic wh, input logic fec);
        logic cb[16];
        logic x;
        for (int i = 0; i < 8; i++) begin
            x = b[7-i] ^ (wh & lfsr[0]);
            if (wh) lfsr = {lfsr[4] ^ lfsr[0], lfsr[8:1]};
            cb[2*i] = x ^ cst[1] ^ cst[0];
            cb[2*i+1] = x ^ cst[2] ^ cst[1] ^ cst[0];
            cst = {x, cst[2:1]};
            if (!fec) exp_q.push_back(x);
        end
        for (int k = 0; k < 16 && fec; k++)
            exp_q.push_back(cb[4*(k%4) + k/4]);
    endtask

    task automatic expect_pkt(input logic [7:0] cfg);
        logic [23:0] c;
        logic        fb;
        exp_q = {};
        lfsr = 9'h1ff;
        c = 24'h0;
        emit(pkt[0], 1'b0, 1'b0);
        cst = 3'h0;
        for (int i = 1; i < 3; i++) begin
            for (int j = 7; j >= 0; j--) begin
                fb = c[23] ^ pkt[i][j];
                c = {c[22:0], 1'b0} ^ (fb ? crc_poly[cfg[2:0]] : 24'h0);
            end
            emit(pkt[i], cfg[3], cfg[4]);
        end
        for (int k = 0; k < crc_bytes[cfg[2:0]]; k++)
            emit(c[23-8*k -: 8], cfg[3], cfg[4]);
        if (cfg[4] && crc_bytes[cfg[2:0]] % 2 == 1)
            emit(8'h00, cfg[3], 1'b1);
        if (cfg[4]) emit(8'h00, 1'b0, 1'b1);
    endtask

    task complete_run;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            failures++;
            complete_run();
        end
    end

    initial begin
        logic [2:0] top;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rdc("pa_ctrl", 5'h04, 8'h07);
        rdc("mod_first", 5'h00, 8'h00);
        wr(5'h06, 8'hff);
        rdc("unmapped", 5'h06, 8'h00);
        for (int j = 0; j < 8; j++) begin
            wr(5'h08 + j[4:0], 8'h90 + j[7:0]);
            rdc("power_entry", 5'h08 + j[4:0], 8'h10 + j[7:0]);
        end
        $display("test registers done");
        wr(5'h01, 8'hff);
        wr(5'h02, 8'h4f);
        for (int m = 0; m < 4; m++) begin
            wr(5'h00, {4'hf, 1'b0, m[0], m[1:0]});
            repeat (2) @(posedge core_clk);
            check("modulation", modulation_q, m[1:0]);
            check("gaussian", gaussian_q, m == 1);
            check("bt_select", gaussian_bt_q, m[0]);
            check("deviation", deviation_q,
                  m == 3 ? 4088 : m == 2 ? 0 : 3840);
        end
        wr(5'h02, 8'h03);
        wr(5'h00, 8'hf0);
        repeat (2) @(posedge core_clk);
        check("deviation_floor", deviation_q, 5);
        wr(5'h00, 8'hf8);
        repeat (2) @(posedge core_clk);
        check("carrier", carrier_only_q, 1);
        check("carrier_dev", deviation_q, 0);
        $display("test modulation done");
        for (int p = 0; p < 9; p++) begin
            top = p == 7 ? 3'd5 : 3'd7;
            wr(5'h03, pkt_cfg[p]);
            wr(5'h04, {4'h0, p == 8, top});
            wr(5'h00, p < 7 ? 8'hf0 : 8'hf2);
            model_u.bits.delete();
            model_u.levels.delete();
            expect_pkt(pkt_cfg[p]);
            for (int i = 0; i < 3; i++) put(pkt[i], i == 0, i == 2);
            do @(posedge core_clk); while (tx_active_q !== 1'b0);
            check("bit_count", model_u.bits.size(), exp_q.size());
            foreach (exp_q[i])
                check("tx_bit", model_u.bits[i], exp_q[i]);
            for (int i = 0; i < model_u.levels.size() && p > 6; i++)
                if (p == 7 || (i > 0 && model_u.bits[i] == model_u.bits[i-1]))
                    check("pa_level", model_u.levels[i],
                          {5'h02, {3{model_u.bits[i]}} & top});
            $display("test packet %0d done", p);
        end
        complete_run();
    end
endmodule
`default_nettype wire
